// ===== smc_map.svh
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// control/status register location and reset
`define SMC_CTRL_ADDR      8'hc0
`define SMC_CTRL_BIT_BASE  5'h18
`define SMC_CTRL_RESET     8'h00

// field positions inside bus_control_status
`define SMC_BIT_MASTER     7
`define SMC_BIT_TXDIR      6
`define SMC_BIT_BEGIN      5
`define SMC_BIT_END        4
`define SMC_BIT_ACKNEED    3
`define SMC_BIT_ARBLOSS    2
`define SMC_BIT_ACK        1
`define SMC_BIT_IRQFLAG    0

// link event indexes
`define SMC_EV_START_DET   0
`define SMC_EV_START_GEN   1
`define SMC_EV_STOP_DET    2
`define SMC_EV_STOP_GEN    3
`define SMC_EV_ADDR_RX     4
`define SMC_EV_BYTE_RX     5
`define SMC_EV_TX_ACK      6
`define SMC_EV_TX_NACK     7
`define SMC_EV_ACK_DONE    8
`define SMC_EV_ARB_LOST    9
`define SMC_EV_ARB_STOP    10
`define SMC_EV_TX_LOAD     11
`define SMC_EV_RX_FRAME    12
`define SMC_EV_NUM         13

// slave-side events that an ignored slave drops
`define SMC_EV_SLAVE_MASK  13'h00f4

// levels passed to the link domain
`define SMC_LV_STALL       0
`define SMC_LV_ACK         1
`define SMC_LV_START       2
`define SMC_LV_STOP        3
`define SMC_LV_MASTER      4
`define SMC_LV_NUM         5

`define SMC_SYNC_DEPTH     3

`endif

// ===== smc_pkg.sv
package smc_pkg;

    typedef enum logic [2:0] {
        SMC_ST_SLAVE  = 3'b001,
        SMC_ST_PEND   = 3'b010,
        SMC_ST_MASTER = 3'b100
    } smc_state_t;

    typedef logic [7:0] smc_byte_t;

endpackage

// ===== smc_event_sync.sv
`timescale 1ns/1ns
`include "smc_map.svh"

// carries one-cycle pulses from the link clock into the system clock as toggles
module smc_event_sync #(
    parameter int WIDTH = `SMC_EV_NUM
) (
    input  wire logic             srcClk,
    input  wire logic             srcRst_n,
    input  wire logic [WIDTH-1:0] srcPulse,
    input  wire logic             dstClk,
    input  wire logic             dstRst_n,
    output logic      [WIDTH-1:0] dstPulse
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic srcToggle;
            logic s1;
            logic s2;
            logic s3;
            logic seen;
            wire  agreed = (s2 == s3) && (s3 != seen);

            always_ff @(posedge srcClk) begin
                if (!srcRst_n)
                    srcToggle <= 1'b0;
                else
                    srcToggle <= srcToggle ^ srcPulse[i];
            end

            // s1 feeds only s2; a change counts once s2 and s3 agree
            always_ff @(posedge dstClk) begin
                if (!dstRst_n) begin
                    s1   <= 1'b0;
                    s2   <= 1'b0;
                    s3   <= 1'b0;
                    seen <= 1'b0;
                end else begin
                    s1   <= srcToggle;
                    s2   <= s1;
                    s3   <= s2;
                    seen <= agreed ? s3 : seen;
                end
            end

            assign dstPulse[i] = agreed;
        end
    endgenerate

endmodule

// ===== smc_control_status.sv
`timescale 1ns/1ns
`include "smc_map.svh"

// Function
// - read-only master and direction bits on top
// - direction bit reads one while transmitting
// - begin/end flags show conditions since interrupt
// - begin write enters master, issues start
// - end write in master issues stop
// - both flags in master: stop then start
// - ack bit: written outgoing, read incoming
// - ack-needed flag set per received byte
// - interrupt cleared without ack write sends nack
// - ack drives data at once, clock waits
// - nacked address ignores slave events until start
// - arbitration loss sets loss flag
// - loss flag cleared when interrupt cleared
// - interrupt flag set on transfer events
// - interrupt flag set stalls, clock held low
// - end flag cleared once stop generated
// - ack-needed flag cleared after ack cycle
module smc_control_status
    import smc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic [7:0] sfrWrData,
    input  wire logic       sfrRdEn,
    output smc_byte_t       sfrRdData,
    input  wire logic [7:0] bitAddr,
    input  wire logic       bitWrEn,
    input  wire logic       bitWrValue,
    input  wire logic       bitRdEn,
    output logic            bitRdValue,
    output logic            irq,
    input  wire logic       linkClk,
    input  wire logic       linkRst_n,
    input  wire logic       linkStartDet,
    input  wire logic       linkStartGen,
    input  wire logic       linkStopDet,
    input  wire logic       linkStopGen,
    input  wire logic       linkAddrRx,
    input  wire logic       linkByteRx,
    input  wire logic       linkByteTx,
    input  wire logic       linkAckIn,
    input  wire logic       linkAckDone,
    input  wire logic       linkArbLost,
    input  wire logic       linkArbLostStop,
    input  wire logic       linkTxLoad,
    input  wire logic       linkRxFrame,
    input  wire logic       linkAckSlot,
    output logic            linkStartReq,
    output logic            linkStopReq,
    output logic            linkMaster,
    output logic            linkSclOut,
    output logic            linkSclOe,
    output logic            linkSdaOut,
    output logic            linkSdaOe
);

    // link events into the system domain
    wire  [`SMC_EV_NUM-1:0] linkEvents = {linkRxFrame, linkTxLoad, linkArbLostStop, linkArbLost, linkAckDone,
                                           linkByteTx & !linkAckIn, linkByteTx & linkAckIn, linkByteRx,
                                           linkAddrRx, linkStopGen, linkStopDet, linkStartGen, linkStartDet};
    logic [`SMC_EV_NUM-1:0] ev;

    smc_event_sync #(
        .WIDTH(`SMC_EV_NUM)
    ) u_event_sync (
        .srcClk   (linkClk),
        .srcRst_n (linkRst_n),
        .srcPulse (linkEvents),
        .dstClk   (clk),
        .dstRst_n (rst_n),
        .dstPulse (ev)
    );

    smc_state_t state;
    smc_state_t next_state;
    logic       txDir;
    logic       beginFlag;
    logic       endFlag;
    logic       ackNeed;
    logic       arbLoss;
    logic       ackBit;
    logic       irqFlag;
    logic       ackWritten;
    logic       addrPending;
    logic       slaveIgnore;

    // register access decode
    wire       byteWr  = sfrWrEn && (sfrAddr == `SMC_CTRL_ADDR);
    wire       bitHit  = (bitAddr[7:3] == `SMC_CTRL_BIT_BASE);
    wire       bitWr   = bitWrEn && bitHit;
    wire [7:0] wrMask  = byteWr ? 8'hff : (bitWr ? (8'h01 << bitAddr[2:0]) : 8'h00);
    wire [7:0] wrVal   = byteWr ? sfrWrData : {8{bitWrValue}};
    wire       master  = (state == SMC_ST_MASTER);
    wire [7:0] ctrlRd  = {master, txDir, beginFlag, endFlag, ackNeed, arbLoss, ackBit, irqFlag};

    // a nacked slave stays deaf until the next start; a start in this very cycle reopens it
    wire       ignoreNow  = slaveIgnore && !ev[`SMC_EV_START_DET];
    wire       slaveGate  = master || !ignoreNow;
    wire [`SMC_EV_NUM-1:0] evSlave = ev & `SMC_EV_SLAVE_MASK;
    wire       slaveEvent = (|evSlave) && slaveGate;
    wire       byteRxG    = ev[`SMC_EV_BYTE_RX] && slaveGate;
    wire       addrRxG    = ev[`SMC_EV_ADDR_RX] && slaveGate;
    wire       arbEvent   = ev[`SMC_EV_ARB_LOST] || ev[`SMC_EV_ARB_STOP];

    wire       irqSet     = ev[`SMC_EV_START_GEN] || arbEvent || slaveEvent;
    wire       irqClear   = wrMask[`SMC_BIT_IRQFLAG] && !wrVal[`SMC_BIT_IRQFLAG] && irqFlag;
    wire       ackWrNow   = wrMask[`SMC_BIT_ACK];
    wire       autoNack   = irqClear && ackNeed && !ackWritten && !ackWrNow;
    wire       ackEff     = (ackWritten || ackWrNow) ? (ackWrNow ? wrVal[`SMC_BIT_ACK] : ackBit) : 1'b0;
    wire       endSet     = (ev[`SMC_EV_STOP_DET] && slaveGate) || ev[`SMC_EV_ARB_STOP];
    wire       txSet      = ev[`SMC_EV_START_GEN] || ev[`SMC_EV_TX_LOAD];
    wire       txClr      = ev[`SMC_EV_START_DET] || arbEvent || ev[`SMC_EV_RX_FRAME];
    // a begin flag set by a received address must not send us onto the bus as master
    wire       startReq   = beginFlag && ((state == SMC_ST_PEND) || (master && endFlag));
    wire       stopReq    = endFlag && master;

    // master/slave role: a begin request waits for the bus, then the generated start makes us master
    always_comb begin
        next_state = state;
        unique case (state)
            SMC_ST_SLAVE: begin
                if (wrMask[`SMC_BIT_BEGIN] && wrVal[`SMC_BIT_BEGIN])
                    next_state = SMC_ST_PEND;
            end
            SMC_ST_PEND: begin
                // a loss in the same cycle as our start leaves us slave
                if (arbEvent)
                    next_state = SMC_ST_SLAVE;
                else if (ev[`SMC_EV_START_GEN])
                    next_state = SMC_ST_MASTER;
                else if (wrMask[`SMC_BIT_BEGIN] && !wrVal[`SMC_BIT_BEGIN])
                    next_state = SMC_ST_SLAVE;
            end
            SMC_ST_MASTER: begin
                if (arbEvent || (ev[`SMC_EV_STOP_GEN] && !ev[`SMC_EV_START_GEN]))
                    next_state = beginFlag && !arbEvent ? SMC_ST_PEND : SMC_ST_SLAVE;
            end
            default: next_state = SMC_ST_SLAVE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            state <= SMC_ST_SLAVE;
        else
            state <= next_state;
    end

    // hardware-set flags win over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txDir     <= 1'b0;
            beginFlag <= 1'b0;
            endFlag   <= 1'b0;
        end else begin
            if (txSet)
                txDir <= 1'b1;
            else if (txClr)
                txDir <= 1'b0;
            if (addrRxG)
                beginFlag <= 1'b1;
            else if (wrMask[`SMC_BIT_BEGIN])
                beginFlag <= wrVal[`SMC_BIT_BEGIN];
            if (endSet)
                endFlag <= 1'b1;
            else if (ev[`SMC_EV_STOP_GEN])
                endFlag <= 1'b0;
            else if (wrMask[`SMC_BIT_END])
                endFlag <= wrVal[`SMC_BIT_END] && master;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackNeed <= 1'b0;
            arbLoss <= 1'b0;
            irqFlag <= 1'b0;
        end else begin
            if (byteRxG || addrRxG)
                ackNeed <= 1'b1;
            else if (ev[`SMC_EV_ACK_DONE])
                ackNeed <= 1'b0;
            if (arbEvent)
                arbLoss <= 1'b1;
            else if (irqClear)
                arbLoss <= 1'b0;
            if (irqSet)
                irqFlag <= 1'b1;
            else if (wrMask[`SMC_BIT_IRQFLAG])
                irqFlag <= wrVal[`SMC_BIT_IRQFLAG];
        end
    end

    // ack bit: incoming value as transmitter, software choice as receiver
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackBit      <= 1'b0;
            ackWritten  <= 1'b0;
            addrPending <= 1'b0;
            slaveIgnore <= 1'b0;
        end else begin
            if (ev[`SMC_EV_TX_ACK])
                ackBit <= 1'b1;
            else if (ev[`SMC_EV_TX_NACK])
                ackBit <= 1'b0;
            else if (ackWrNow)
                ackBit <= wrVal[`SMC_BIT_ACK];
            else if (autoNack)
                ackBit <= 1'b0;
            if (byteRxG || addrRxG)
                ackWritten <= 1'b0;
            else if (ackWrNow)
                ackWritten <= 1'b1;
            if (addrRxG && !master)
                addrPending <= 1'b1;
            else if (irqClear)
                addrPending <= 1'b0;
            if (ev[`SMC_EV_START_DET])
                slaveIgnore <= 1'b0;
            else if (irqClear && addrPending && !ackEff)
                slaveIgnore <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfrRdData  <= `SMC_CTRL_RESET;
            bitRdValue <= 1'b0;
            irq        <= 1'b0;
        end else begin
            sfrRdData  <= (sfrRdEn && (sfrAddr == `SMC_CTRL_ADDR)) ? ctrlRd : 8'h00;
            bitRdValue <= bitRdEn && bitHit && ctrlRd[bitAddr[2:0]];
            irq        <= irqFlag;
        end
    end

    // system levels into the link domain: three flops, taken once the last two agree
    wire [`SMC_LV_NUM-1:0] sysLevels = {master, stopReq, startReq, ackBit, irqFlag};
    logic [`SMC_LV_NUM-1:0] linkLevels;

    genvar i;
    generate
        for (i = 0; i < `SMC_LV_NUM; i++) begin : g_level
            logic l1;
            logic l2;
            logic l3;
            logic lv;
            always_ff @(posedge linkClk) begin
                if (!linkRst_n) begin
                    l1 <= 1'b0;
                    l2 <= 1'b0;
                    l3 <= 1'b0;
                    lv <= 1'b0;
                end else begin
                    l1 <= sysLevels[i];
                    l2 <= l1;
                    l3 <= l2;
                    lv <= (l2 == l3) ? l3 : lv;
                end
            end

            assign linkLevels[i] = lv;
        end
    endgenerate

    // clock held low while the interrupt flag stands; ack pulls data low only in our ack slot
    always_ff @(posedge linkClk) begin
        if (!linkRst_n) begin
            linkSclOe    <= 1'b0;
            linkSdaOe    <= 1'b0;
            linkStartReq <= 1'b0;
            linkStopReq  <= 1'b0;
            linkMaster   <= 1'b0;
        end else begin
            linkSclOe    <= linkLevels[`SMC_LV_STALL];
            linkSdaOe    <= linkAckSlot && linkLevels[`SMC_LV_ACK];
            linkStartReq <= linkLevels[`SMC_LV_START];
            linkStopReq  <= linkLevels[`SMC_LV_STOP];
            linkMaster   <= linkLevels[`SMC_LV_MASTER];
        end
    end

    assign linkSclOut = 1'b0;
    assign linkSdaOut = 1'b0;

    // checks in the system domain, plus one stall check on the link clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire noEvents = (ev == '0);

    AST_ROLE_READ_ONLY: assert property (byteWr && noEvents && (state != SMC_ST_SLAVE) &&
                                         !(wrMask[`SMC_BIT_BEGIN] && !wrVal[`SMC_BIT_BEGIN])
                                         |=> $stable(master))
        else $error("role bit changed by a write");
    AST_DIR_READ_ONLY: assert property (byteWr && noEvents |=> $stable(txDir))
        else $error("direction bit changed by a write");
    AST_BEGIN_ON_ADDR: assert property (ev[`SMC_EV_ADDR_RX] && slaveGate |=> beginFlag && irqFlag)
        else $error("begin flag not set by received address");
    AST_BEGIN_HELD: assert property (beginFlag && !wrMask[`SMC_BIT_BEGIN] |=> beginFlag)
        else $error("begin flag dropped without a write");
    AST_BEGIN_TO_PEND: assert property (state == SMC_ST_SLAVE && wrMask[`SMC_BIT_BEGIN] && wrVal[`SMC_BIT_BEGIN]
                                        |=> state == SMC_ST_PEND ##0 startReq)
        else $error("begin write did not request a start");
    AST_RESTART: assert property (master && endFlag && beginFlag |-> stopReq && startReq)
        else $error("stop then start not requested");
    AST_STOP_CLEARS: assert property (ev[`SMC_EV_STOP_GEN] && !endSet |=> !endFlag)
        else $error("end flag not cleared after stop");
    AST_ACKNEED_SET: assert property (byteRxG |=> ackNeed && irqFlag && !ackWritten)
        else $error("ack-needed flag not set on byte");
    AST_ACKNEED_CLR: assert property (ev[`SMC_EV_ACK_DONE] && !byteRxG && !addrRxG |=> !ackNeed)
        else $error("ack-needed flag not cleared");
    AST_AUTO_NACK: assert property (autoNack && !ev[`SMC_EV_TX_ACK] |=> !ackBit)
        else $error("missing ack write did not give nack");
    AST_ARB_SETS: assert property (ev[`SMC_EV_ARB_LOST] |=> arbLoss && irqFlag && !master)
        else $error("arbitration loss not flagged");
    AST_ARB_CLEARS: assert property (irqClear && !arbEvent |=> !arbLoss)
        else $error("loss flag survived interrupt clear");
    AST_IGNORED_SLAVE: assert property (slaveIgnore && !master && !irqFlag && !wrMask[`SMC_BIT_IRQFLAG]
                                        && ((ev & ~`SMC_EV_SLAVE_MASK) == '0) |=> !irqFlag)
        else $error("ignored slave raised an interrupt");
    AST_IRQ_FOLLOWS: assert property (irqFlag |=> irq)
        else $error("interrupt request not raised");

    COV_BEGIN_WRITE: cover property (state == SMC_ST_PEND ##1 state == SMC_ST_MASTER);
    COV_RESTART: cover property (master && startReq && stopReq);
    COV_BYTE_NACK: cover property (byteRxG ##[1:50] autoNack);
    COV_ARB_LOSS: cover property (ev[`SMC_EV_ARB_LOST] ##[1:50] irqClear);

    AST_LINK_STALL: assert property (@(posedge linkClk) disable iff (!linkRst_n)
                                     linkLevels[`SMC_LV_STALL] |=> linkSclOe)
        else $error("clock not held low during stall");

endmodule

// ===== smc_link_model.sv
`timescale 1ns/1ns
`include "smc_map.svh"

// stand-in for the shift datapath and the bus behind it, living on the link clock
module smc_link_model #(
    parameter int GAP = 60
) (
    input  wire logic        linkClk,
    input  wire logic        linkStartReq,
    input  wire logic        linkStopReq,
    output logic      [12:0] ev,
    output logic             ackIn,
    output logic             ackSlot
);
    logic junk;
    int   waitCnt;

    initial begin
        ev      = '0;
        junk    = 1'b0;
        waitCnt = 0;
        ackSlot = 1'b0;
    end

    task automatic fire(input int idx);
        @(posedge linkClk);
        ev[idx] <= 1'b1;
        @(posedge linkClk);
        ev[idx] <= 1'b0;
    endtask

    // ack level only means something beside the byte pulse, so it wanders otherwise
    assign ackIn = (ev[`SMC_EV_TX_ACK] | ev[`SMC_EV_TX_NACK]) ? ev[`SMC_EV_TX_ACK] : junk;

    // first answer is prompt, then a bus-free gap so a stop and a start never share a slot
    always @(posedge linkClk) begin
        junk <= ~junk;
        ev[`SMC_EV_STOP_GEN]  <= (waitCnt == 0) && linkStopReq;
        ev[`SMC_EV_START_GEN] <= (waitCnt == 0) && !linkStopReq && linkStartReq;
        if (waitCnt == 0 && (linkStopReq || linkStartReq)) begin
            waitCnt <= GAP;
        end else if (waitCnt != 0) begin
            waitCnt <= waitCnt - 1;
        end
    end
endmodule

// ===== smbus_control_status_tb.sv
`timescale 1ns/1ns

`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin numErrors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module smbus_control_status_tb
    import smc_pkg::*;
;
    logic        clk, linkClk, rst_n, linkRst_n;
    logic [7:0]  sfrAddr, sfrWrData, bitAddr;
    logic        sfrWrEn, sfrRdEn, bitWrEn, bitWrValue, bitRdEn;
    smc_byte_t   sfrRdData;
    logic        bitRdValue, irq, linkStartReq, linkStopReq, linkMaster;
    logic        linkSclOut, linkSclOe, linkSdaOut, linkSdaOe, ackIn, ackSlot;
    logic [12:0] ev;
    int          numErrors = 0;
    int          numChecks = 0;
    time         stopT, startT;

    smc_link_model u_link (.linkClk(linkClk), .linkStartReq(linkStartReq), .linkStopReq(linkStopReq),
                           .ev(ev), .ackIn(ackIn), .ackSlot(ackSlot));

    smc_control_status u_dut (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
        .bitWrEn(bitWrEn), .bitWrValue(bitWrValue), .bitRdEn(bitRdEn), .bitRdValue(bitRdValue),
        .irq(irq), .linkClk(linkClk), .linkRst_n(linkRst_n), .linkStartDet(ev[0]), .linkStartGen(ev[1]),
        .linkStopDet(ev[2]), .linkStopGen(ev[3]), .linkAddrRx(ev[4]), .linkByteRx(ev[5]),
        .linkByteTx(ev[6] | ev[7]), .linkAckIn(ackIn), .linkAckDone(ev[8]), .linkArbLost(ev[9]),
        .linkArbLostStop(ev[10]), .linkTxLoad(ev[11]), .linkRxFrame(ev[12]), .linkAckSlot(ackSlot),
        .linkStartReq(linkStartReq), .linkStopReq(linkStopReq), .linkMaster(linkMaster),
        .linkSclOut(linkSclOut), .linkSclOe(linkSclOe), .linkSdaOut(linkSdaOut), .linkSdaOe(linkSdaOe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        linkClk = 1'b0;
        #5;
        forever #6 linkClk = ~linkClk;
    end

    always @(posedge linkClk) begin
        if (ev[3]) stopT = $time;
        if (ev[1]) startT = $time;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input smc_byte_t d);
        @(posedge clk);
        sfrAddr   <= a;
        sfrWrData <= d;
        sfrWrEn   <= 1'b1;
        @(posedge clk);
        sfrWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output smc_byte_t v);
        @(posedge clk);
        sfrAddr <= a;
        sfrRdEn <= 1'b1;
        @(posedge clk);
        sfrRdEn <= 1'b0;
        #1 v = sfrRdData;
    endtask

    task automatic bitwr(input logic [2:0] i, input logic b);
        @(posedge clk);
        bitAddr    <= {5'h18, i};
        bitWrValue <= b;
        bitWrEn    <= 1'b1;
        @(posedge clk);
        bitWrEn <= 1'b0;
    endtask

    task automatic bitrd(input logic [2:0] i, output logic b);
        @(posedge clk);
        bitAddr <= {5'h18, i};
        bitRdEn <= 1'b1;
        @(posedge clk);
        bitRdEn <= 1'b0;
        #1 b = bitRdValue;
    endtask

    // an event reaches the flags 4..5 clk after its link pulse; 10 leaves margin
    task automatic fireEv(input int i);
        u_link.fire(i);
        idle(10);
    endtask

    task automatic giveVerdict;
        $display("checks=%0d errors=%0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        giveVerdict;
    end

    initial begin
        smc_byte_t v;
        logic      b;
        {rst_n, linkRst_n, sfrWrEn, sfrRdEn, bitWrEn, bitWrValue, bitRdEn} = '0;
        {sfrAddr, bitAddr, sfrWrData} = {8'hc0, 8'hc0, 8'h00};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge linkClk) linkRst_n <= 1'b1;
        rd(8'hc0, v); `CHK(v, 8'h00)
        wr(8'hc0, 8'hdc); rd(8'hc0, v); `CHK(v, 8'h00)
        wr(8'hc1, 8'hff); rd(8'hc1, v); `CHK(v, 8'h00)
        wr(8'hc0, 8'h03); idle(2); rd(8'hc0, v); `CHK(v, 8'h03)
        `CHK(irq, 1'b1)
        idle(10); `CHK({linkSclOe, linkSclOut}, 2'b10)
        wr(8'hc0, 8'h00); idle(10); `CHK(irq, 1'b0)
        `CHK(linkSclOe, 1'b0)
        // master start, then a transmitted byte acked and one nacked
        wr(8'hc0, 8'h20); idle(20); rd(8'hc0, v); `CHK(v & 8'hb1, 8'ha1)
        `CHK(linkMaster, 1'b1)
        `CHK(irq, 1'b1)
        wr(8'hc0, 8'h00); fireEv(11); bitrd(3'd6, b); `CHK(b, 1'b1)
        fireEv(6); rd(8'hc0, v); `CHK(v, 8'hc3)
        bitwr(3'd0, 1'b0); fireEv(7); rd(8'hc0, v); `CHK(v & 8'h03, 8'h01)
        fireEv(12); bitrd(3'd6, b); `CHK(b, 1'b0)
        stopT = 0;
        startT = 0;
        wr(8'hc0, 8'h30); idle(60); `CHK((stopT != 0) && (stopT < startT), 1'b1)
        rd(8'hc0, v); `CHK(v & 8'h90, 8'h80)
        wr(8'hc0, 8'h10); idle(60); rd(8'hc0, v); `CHK(v & 8'hb0, 8'h00)
        `CHK(linkMaster, 1'b0)
        // slave receive with an explicit ack
        bitwr(3'd0, 1'b0); fireEv(4); bitrd(3'd3, b); `CHK(b, 1'b1)
        `CHK(linkStartReq, 1'b0)
        `CHK(irq, 1'b1)
        u_link.ackSlot <= 1'b1;
        bitwr(3'd1, 1'b1); idle(4); `CHK({linkSdaOe, linkSdaOut}, 2'b10)
        `CHK(linkSclOe, 1'b1)
        bitwr(3'd0, 1'b0); idle(4); `CHK(linkSclOe, 1'b0)
        u_link.ackSlot <= 1'b0;
        fireEv(8); bitrd(3'd3, b); `CHK(b, 1'b0)
        // address left unanswered: nack, then deaf until the next start
        fireEv(4); u_link.ackSlot <= 1'b1;
        bitwr(3'd0, 1'b0); idle(4); bitrd(3'd1, b); `CHK(b, 1'b0)
        `CHK(linkSdaOe, 1'b0)
        u_link.ackSlot <= 1'b0;
        fireEv(8); fireEv(5); bitrd(3'd0, b); `CHK(b, 1'b0)
        fireEv(0); fireEv(5); bitrd(3'd3, b); `CHK(b, 1'b1)
        bitwr(3'd0, 1'b0); fireEv(8); fireEv(9); rd(8'hc0, v); `CHK(v & 8'h05, 8'h05)
        bitwr(3'd0, 1'b0); idle(2); bitrd(3'd2, b); `CHK(b, 1'b0)
        giveVerdict;
    end
endmodule
